// ---- hdl/timer_ctrl_consts.vh ----
// Constants for the timer control register block.
`ifndef TIMER_CTRL_CONSTS_VH
`define TIMER_CTRL_CONSTS_VH
`define RIDX_READ_REQ      8'h02
`define RIDX_CTRL_B_CLR    8'h04
`define RIDX_CTRL_B_SET    8'h05
`define RIDX_CTRL_C        8'h06
`define RIDX_DEBUG         8'h08
`define RIDX_STATUS        8'h0f
`define RIDX_SWRST         8'h10
`define ADDR_LSB           2
`define ADDR_W             8
`define RR_ADDR_HI         4
`define RR_REQ_BIT         15
`define RR_ADDR_W          5
`define COUNT_OFFSET       5'h10
`define CC_OFFSET_LO       5'h18
`define CC_OFFSET_HI       5'h1f
`define CMD_HI             7
`define CMD_LO             6
`define SINGLE_PASS_ENABLE_BIT        2
`define DIR_BIT            0
`define CMD_NONE           2'h0
`define CMD_RETRIGGER      2'h1
`define CMD_STOP           2'h2
`define CMD_RESERVED       2'h3
`define CPT_LO             4
`define CPT_HI             5
`define INV_HI             1
`define DBG_BIT            0
`define RESET_BYTE         8'h00
`define SYNC_CYCLES        3'h2
`define HTRANS_NONSEQ_BIT  1
`endif

// ---- hdl/timer_ctrl_regs.v ----
// Timer control registers reached over AHB-Lite, with command hand-off to the counting core.
`timescale 1ns/1ns
`include "timer_ctrl_consts.vh"
module timer_ctrl_regs (
   input  wire        CLK,
   input  wire        NRST,
   input  wire        HSEL,
   input  wire [31:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output reg  [31:0] HRDATA,
   output reg         HREADYOUT,
   output reg         HRESP,
   input  wire        WRITE_PROTECT,
   input  wire        PRESC_TICK,
   input  wire        WRAP_EVENT,
   input  wire        DEBUG_HALT,
   output reg         CMD_RETRIGGER,
   output reg         CMD_STOP,
   output reg         COUNT_DOWN,
   output reg         SINGLE_PASS_ENABLE,
   output reg         SINGLE_PASS_ENABLE_STOP,
   output reg  [1:0]  CAPTURE_SELECT,
   output reg  [1:0]  OUTPUT_INVERT,
   output reg         RUN_WHILE_HALTED,
   output reg         COUNTER_HALT,
   output reg         READ_SYNC_REQUEST,
   output reg  [4:0]  READ_SYNC_ADDR,
   output reg         SYNC_BUSY_FLAG
);

   // Address phase capture.
   reg                 wr_pend_q;
   reg                 rd_pend_q;
   reg [`ADDR_W-1:0]   idx_q;

   // Register fields as software sees them.
   reg [1:0]           cmd_q;
   reg                 single_pass_enable_q;
   reg                 dir_q;
   reg [1:0]           cpt_q;
   reg [1:0]           inv_q;
   reg                 dbg_q;

   // Read synchronization state.
   reg [`RR_ADDR_W-1:0] rr_addr_q;
   reg [2:0]           sync_cnt_q;
   reg                 busy_q;
   reg [7:0]           rd_byte;
   reg [`RR_ADDR_W-1:0] wr_rr_addr;

   // Decoded strobes of the current address and data phases.
   wire                take;
   wire                wr_ok;
   wire [7:0]          wb;
   wire                rr_eligible;
   wire                rr_accept;
   wire                rr_fire;

   // A transfer is taken when the slave is selected, the bus is ready and HTRANS is NONSEQ or SEQ.
   assign take  = HSEL && HREADY && HTRANS[`HTRANS_NONSEQ_BIT];
   assign wb    = HWDATA[7:0];
   assign wr_ok = wr_pend_q && !WRITE_PROTECT;
   // Only the counter value and capture/compare offsets may be read-synchronized.
   assign rr_eligible = (wr_rr_addr == `COUNT_OFFSET) ||
                        ((wr_rr_addr >= `CC_OFFSET_LO) && (wr_rr_addr <= `CC_OFFSET_HI));
   // An eligible address is taken on any write; a one in the request bit
   // also starts the hand-off, so the address and the request leave together.
   assign rr_accept = wr_ok && (idx_q == `RIDX_READ_REQ) && rr_eligible;
   assign rr_fire   = rr_accept && HWDATA[`RR_REQ_BIT];

   // Address field of a read request, as written.
   always @* begin
      wr_rr_addr = HWDATA[`RR_ADDR_HI:0];
   end

   // Bus slave: one-cycle address capture, always OKAY. A write is answered
   // without wait states and lands at the edge that ends its data phase. A
   // read inserts one wait state, so that its data can come from a flop and
   // already shows a write that finished just before it.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         idx_q     <= `RESET_BYTE;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         wr_pend_q <= take && HWRITE;
         rd_pend_q <= take && !HWRITE;
         // The index is held until the next address phase, through any wait.
         if (take) begin
            idx_q <= HADDR[`ADDR_W+`ADDR_LSB-1:`ADDR_LSB];
         end
         // Ready drops only in the first data-phase cycle of a read.
         HREADYOUT <= !(take && !HWRITE);
         HRESP     <= 1'b0;
      end
   end

   // Read mux: both control views show the same register, so a change made
   // through one view shows at once through the other. Unmapped offsets and
   // the write-only bits read as zero.
   always @* begin
      rd_byte = `RESET_BYTE;
      if ((idx_q == `RIDX_CTRL_B_CLR) || (idx_q == `RIDX_CTRL_B_SET)) begin
         rd_byte = {cmd_q, 3'h0, single_pass_enable_q, 1'b0, dir_q};
      end else if (idx_q == `RIDX_CTRL_C) begin
         rd_byte = {2'h0, cpt_q, 2'h0, inv_q};
      end else if (idx_q == `RIDX_DEBUG) begin
         rd_byte = {7'h00, dbg_q};
      end else if (idx_q == `RIDX_READ_REQ) begin
         rd_byte = {3'h0, rr_addr_q};
      end else if (idx_q == `RIDX_STATUS) begin
         rd_byte = {7'h00, busy_q};
      end else begin
         rd_byte = `RESET_BYTE;
      end
   end

   // Read data is loaded in the wait state of a read, from the index held
   // since the address phase, and then stands through the last data-phase
   // cycle, where the master takes it.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         HRDATA <= {24'h000000, rd_byte};
      end
   end

   // Control register B, capture/inversion and command handling. A tick
   // retires the pending command; a write in the same cycle is applied after
   // it and so wins, which keeps a freshly posted command from being lost.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cmd_q     <= `CMD_NONE;
         single_pass_enable_q <= 1'b0;
         dir_q     <= 1'b0;
         cpt_q     <= 2'h0;
         inv_q     <= 2'h0;
      end else if (wr_ok && (idx_q == `RIDX_SWRST) && wb[0]) begin
         cmd_q     <= `CMD_NONE;
         single_pass_enable_q <= 1'b0;
         dir_q     <= 1'b0;
         cpt_q     <= 2'h0;
         inv_q     <= 2'h0;
      end else begin
         // Executed command reads back as zero.
         if (PRESC_TICK) begin
            cmd_q <= `CMD_NONE;
         end
         if (wr_ok && (idx_q == `RIDX_CTRL_B_CLR)) begin
            if (wb[`CMD_HI:`CMD_LO] != `CMD_NONE) begin
               cmd_q <= `CMD_NONE;
            end
            if (wb[`SINGLE_PASS_ENABLE_BIT]) begin
               single_pass_enable_q <= 1'b0;
            end
            if (wb[`DIR_BIT]) begin
               dir_q <= 1'b0;
            end
         end
         if (wr_ok && (idx_q == `RIDX_CTRL_B_SET)) begin
            if ((wb[`CMD_HI:`CMD_LO] != `CMD_NONE) &&
                (wb[`CMD_HI:`CMD_LO] != `CMD_RESERVED)) begin
               cmd_q <= wb[`CMD_HI:`CMD_LO];
            end
            if (wb[`SINGLE_PASS_ENABLE_BIT]) begin
               single_pass_enable_q <= 1'b1;
            end
            if (wb[`DIR_BIT]) begin
               dir_q <= 1'b1;
            end
         end
         // Capture and inversion bits are plain read/write fields.
         if (wr_ok && (idx_q == `RIDX_CTRL_C)) begin
            cpt_q <= wb[`CPT_HI:`CPT_LO];
            inv_q <= wb[`INV_HI:0];
         end
      end
   end

   // Debug control is untouched by the software reset, so a debugger that
   // lets the counter run keeps that choice across it.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dbg_q <= 1'b0;
      end else if (wr_ok && (idx_q == `RIDX_DEBUG)) begin
         dbg_q <= wb[`DBG_BIT];
      end
   end

   // Read synchronization: a request, or a write to a synchronized control
   // register, sets busy for a fixed hand-off time. A new start in the cycle
   // in which the count runs out wins, so busy never drops under a transfer.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rr_addr_q  <= `COUNT_OFFSET;
         busy_q     <= 1'b0;
         sync_cnt_q <= 3'h0;
      end else begin
         if (busy_q) begin
            if (sync_cnt_q == 3'h0) begin
               busy_q <= 1'b0;
            end else begin
               sync_cnt_q <= sync_cnt_q - 3'h1;
            end
         end
         if (rr_accept) begin
            rr_addr_q <= wr_rr_addr;
            if (rr_fire) begin
               busy_q     <= 1'b1;
               sync_cnt_q <= `SYNC_CYCLES;
            end
         end
         // Writes to control registers B and C are handed across too and report busy meanwhile.
         if (wr_ok && ((idx_q == `RIDX_CTRL_B_CLR) || (idx_q == `RIDX_CTRL_B_SET) ||
                       (idx_q == `RIDX_CTRL_C))) begin
            busy_q     <= 1'b1;
            sync_cnt_q <= `SYNC_CYCLES;
         end
      end
   end

   // Strobes to the counting core: one pulse for each executed command, at the edge
   // after the tick that executes it, and a single pass stop at the edge after a wrap while single pass is enabled.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CMD_RETRIGGER      <= 1'b0;
         CMD_STOP           <= 1'b0;
         SINGLE_PASS_ENABLE_STOP       <= 1'b0;
      end else begin
         CMD_RETRIGGER      <= PRESC_TICK && (cmd_q == `CMD_RETRIGGER);
         CMD_STOP           <= PRESC_TICK && (cmd_q == `CMD_STOP);
         SINGLE_PASS_ENABLE_STOP       <= WRAP_EVENT && single_pass_enable_q;
      end
   end

   // Mode copies for the counting core, one cycle behind the register fields.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         COUNT_DOWN         <= 1'b0;
         SINGLE_PASS_ENABLE <= 1'b0;
         CAPTURE_SELECT     <= 2'h0;
         OUTPUT_INVERT      <= 2'h0;
      end else begin
         COUNT_DOWN         <= dir_q;
         SINGLE_PASS_ENABLE <= single_pass_enable_q;
         CAPTURE_SELECT     <= cpt_q;
         OUTPUT_INVERT      <= inv_q;
      end
   end

   // Debug halt: the counter stops with the device unless the run bit is set.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RUN_WHILE_HALTED   <= 1'b0;
         COUNTER_HALT       <= 1'b0;
      end else begin
         RUN_WHILE_HALTED   <= dbg_q;
         COUNTER_HALT       <= DEBUG_HALT && !dbg_q;
      end
   end

   // Read synchronization outputs. The address leaves with its request, so
   // the counting core never pairs a request with the previous address.
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         READ_SYNC_REQUEST  <= 1'b0;
         READ_SYNC_ADDR     <= `COUNT_OFFSET;
         SYNC_BUSY_FLAG     <= 1'b0;
      end else begin
         READ_SYNC_REQUEST  <= rr_fire;
         if (rr_accept) begin
            READ_SYNC_ADDR  <= wr_rr_addr;
         end else begin
            READ_SYNC_ADDR  <= rr_addr_q;
         end
         SYNC_BUSY_FLAG     <= busy_q;
      end
   end

endmodule // timer_ctrl_regs

// ---- tb/timer_ctrl_regs_bench.sv ----
// Self-checking bench for the timer control register block.
`timescale 1ns/1ns
module timer_ctrl_regs_bench;
   logic clk = 0, nrst = 0, sel = 0, wrt = 0, wp = 0, tick = 0, wrap = 0, dh = 0;
   logic [31:0] addr = 0, wd = 0, rd, r;
   logic [1:0]  trans = 0, cap, inv;
   logic [2:0]  size = 3'h2;
   logic        rdy, resp, rtg, stp, down, spe, ost, run, halt, read_sync_request, busy;
   logic [4:0]  raddr;
   logic [7:0]  cb, d;
   int          num_errors = 0, n_tests = 0, i;
   // Clock of 100 MHz.
   always #5 clk = ~clk;
   timer_ctrl_regs timer_ctrl_regs_i (.CLK(clk), .NRST(nrst), .HSEL(sel), .HADDR(addr),
      .HTRANS(trans), .HWRITE(wrt), .HSIZE(size), .HWDATA(wd), .HREADY(rdy), .HRDATA(rd),
      .HREADYOUT(rdy), .HRESP(resp), .WRITE_PROTECT(wp), .PRESC_TICK(tick),
      .WRAP_EVENT(wrap), .DEBUG_HALT(dh), .CMD_RETRIGGER(rtg), .CMD_STOP(stp),
      .COUNT_DOWN(down), .SINGLE_PASS_ENABLE(spe), .SINGLE_PASS_ENABLE_STOP(ost),
      .CAPTURE_SELECT(cap), .OUTPUT_INVERT(inv), .RUN_WHILE_HALTED(run),
      .COUNTER_HALT(halt), .READ_SYNC_REQUEST(read_sync_request), .READ_SYNC_ADDR(raddr),
      .SYNC_BUSY_FLAG(busy));
   // Expected control byte after a clear or set view write of mode bits.
   function automatic logic [7:0] nb(input logic s, input logic [7:0] o, input logic [7:0] v);
      nb = s ? (o | (v & 8'h05)) : (o & ~(v & 8'h05));
   endfunction
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   // One single AHB transfer; read data is taken at the end of the data phase.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
      sel <= 1; trans <= 2'h2; wrt <= w; addr <= a;
      @(posedge clk); while (!rdy) @(posedge clk);
      sel <= 0; trans <= 2'h0; wd <= v;
      @(posedge clk); while (!rdy) @(posedge clk);
      r = rd;
   endtask
   task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
      bus(0, a, 0); check(n, e, r);
   endtask
   task automatic step(input int n); repeat (n) @(posedge clk); endtask
   // Pulse the tick or the wrap input, then stop at the edge where results stand.
   task automatic pulse(input logic k);
      if (k) tick <= 1; else wrap <= 1;
      @(posedge clk); tick <= 0; wrap <= 0; @(posedge clk);
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin #200000; num_errors++; print_verdict; end
   initial begin
      i = $urandom(32'h9f312963); cb = 0;
      step(16); nrst <= 1; step(1);
      rdc("ctrl_b", 32'h10, 0);
      rdc("ctrl_c", 32'h18, 0);
      rdc("debug", 32'h20, 0);
      rdc("unmapped", 32'h7c, 0);
      // Random mode bits through alternate views, read back through the other one.
      for (i = 0; i < 8; i++) begin
         d = 8'($urandom) & 8'h05; bus(1, i[0] ? 32'h14 : 32'h10, {24'h0, d});
         cb = nb(i[0], cb, d);
         rdc("view", i[0] ? 32'h10 : 32'h14, {24'h0, cb});
         check("down", cb[0], down);
         check("single", cb[2], spe);
      end
      for (i = 1; i < 4; i++) begin
         bus(1, 32'h14, {24'h0, i[1:0], 6'h0}); pulse(1);
         check("retrig", i == 1, rtg);
         check("stop", i == 2, stp);
         rdc("cmd_read", 32'h10, {24'h0, cb});
      end
      bus(1, 32'h14, 32'h40); bus(1, 32'h10, 0); pulse(1);
      check("kept", 1, rtg);
      bus(1, 32'h14, 32'h80); bus(1, 32'h10, 32'hc0); pulse(1);
      check("cancel", 0, stp);
      for (i = 0; i < 4; i++) begin
         d = 8'($urandom) & 8'h33; bus(1, 32'h18, {24'h0, d});
         rdc("ctrl_c", 32'h18, {24'h0, d});
         check("capture", d[5:4], cap);
         check("invert", d[1:0], inv);
      end
      wp <= 1; bus(1, 32'h18, {24'h0, ~d}); wp <= 0;
      rdc("protect", 32'h18, {24'h0, d});
      dh <= 1; bus(1, 32'h20, 1); bus(1, 32'h14, 32'h05); bus(1, 32'h40, 1); step(4);
      rdc("swrst", 32'h20, 1);
      rdc("swrst_b", 32'h10, 0);
      check("run", 1, run);
      check("no_halt", 0, halt);
      bus(1, 32'h20, 0); step(2);
      check("halt", 1, halt);
      check("no_run", 0, run);
      // The request pulse stands one cycle with its address, which then holds; busy follows.
      bus(1, 32'h08, 32'h801b); step(1);
      check("read_sync_request", 1, read_sync_request);
      check("raddr", 5'h1b, raddr);
      step(1);
      check("busy", 1, busy);
      step(4); bus(1, 32'h08, 32'h8005); step(1);
      check("no_read_sync_request", 0, read_sync_request);
      step(1);
      check("inelig", 0, busy);
      check("raddr_kept", 5'h1b, raddr);
      bus(1, 32'h14, 4); step(2); pulse(0);
      check("ostop", 1, ost);
      bus(1, 32'h10, 4); step(2); pulse(0);
      check("ocont", 0, ost);
      check("resp", 0, resp);
      print_verdict;
   end
endmodule // timer_ctrl_regs_bench

// ---- tb/timer_ctrl_regs_chk.sv ----
// Port-level assertions for the timer control register block.
`timescale 1ns/1ns
module timer_ctrl_regs_chk (
   input wire logic       CLK,
   input wire logic       NRST,
   input wire logic       PRESC_TICK,
   input wire logic       WRAP_EVENT,
   input wire logic       DEBUG_HALT,
   input wire logic       CMD_RETRIGGER,
   input wire logic       CMD_STOP,
   input wire logic       SINGLE_PASS_ENABLE,
   input wire logic       SINGLE_PASS_ENABLE_STOP,
   input wire logic       RUN_WHILE_HALTED,
   input wire logic       COUNTER_HALT,
   input wire logic       READ_SYNC_REQUEST,
   input wire logic [4:0] READ_SYNC_ADDR,
   input wire logic       SYNC_BUSY_FLAG
);
   default clocking dc @(posedge CLK); endclocking
   default disable iff (!NRST);
   // The run bit seen high for two cycles, so any lag of the copy has passed.
   sequence s_run_held; RUN_WHILE_HALTED [*2]; endsequence
   property p_cmd_tick; CMD_RETRIGGER || CMD_STOP |-> $past(PRESC_TICK); endproperty
   property p_cmd_one; !(CMD_RETRIGGER && CMD_STOP); endproperty
   property p_cmd_pulse; CMD_RETRIGGER || CMD_STOP |=> !CMD_RETRIGGER && !CMD_STOP; endproperty
   property p_stop; SINGLE_PASS_ENABLE_STOP |-> $past(WRAP_EVENT)
      && (SINGLE_PASS_ENABLE || $past(SINGLE_PASS_ENABLE)); endproperty
   property p_nohalt; !DEBUG_HALT |=> !COUNTER_HALT; endproperty
   property p_runs; s_run_held |-> !COUNTER_HALT; endproperty
   property p_busy; READ_SYNC_REQUEST |-> ##[0:1] SYNC_BUSY_FLAG; endproperty
   property p_elig; READ_SYNC_REQUEST |-> READ_SYNC_ADDR == 5'h10 || READ_SYNC_ADDR >= 5'h18;
   endproperty
   a_cmd_tick: assert property (p_cmd_tick) else $error("command without tick");
   a_cmd_one: assert property (p_cmd_one) else $error("two commands at once");
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command repeated");
   a_stop: assert property (p_stop) else $error("stray single pass stop");
   a_nohalt: assert property (p_nohalt) else $error("halt without debug");
   a_runs: assert property (p_runs) else $error("halt while run bit set");
   a_busy: assert property (p_busy) else $error("request without busy");
   a_elig: assert property (p_elig) else $error("ineligible sync address");
endmodule // timer_ctrl_regs_chk
bind timer_ctrl_regs timer_ctrl_regs_chk timer_ctrl_regs_chk_i (.CLK(CLK), .NRST(NRST),
   .PRESC_TICK(PRESC_TICK), .WRAP_EVENT(WRAP_EVENT), .DEBUG_HALT(DEBUG_HALT),
   .CMD_RETRIGGER(CMD_RETRIGGER), .CMD_STOP(CMD_STOP), .SINGLE_PASS_ENABLE_STOP(SINGLE_PASS_ENABLE_STOP),
   .SINGLE_PASS_ENABLE(SINGLE_PASS_ENABLE), .RUN_WHILE_HALTED(RUN_WHILE_HALTED),
   .COUNTER_HALT(COUNTER_HALT), .READ_SYNC_REQUEST(READ_SYNC_REQUEST),
   .READ_SYNC_ADDR(READ_SYNC_ADDR), .SYNC_BUSY_FLAG(SYNC_BUSY_FLAG));
